//--- core/opc_defs.svh
`ifndef OPC_DEFS_SVH
`define OPC_DEFS_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define OPC_CLK_PERIOD_NS 25
`define OPC_PUMP_UP_NS 11000000
`define OPC_HP_UP_NS 35000000

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OPC_ADDR_CTRL 8'h00
`define OPC_ADDR_STATUS 8'h04
`define OPC_ADDR_INT_STATUS 8'h08
`define OPC_ADDR_INT_MASK 8'h0c

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define OPC_CTRL_W 12
`define OPC_CTRL_RESET 12'h000
`define OPC_F_VCM 0
`define OPC_F_HPL 1
`define OPC_F_HPR 2
`define OPC_F_LSV 3
`define OPC_F_SPK 4
`define OPC_F_SAVE_EXIT 5
`define OPC_F_PUMP_CLK 6
`define OPC_F_MONO 7
`define OPC_F_FLOAT 8
`define OPC_F_ALC 9
`define OPC_F_GAIN_LO 10

// ----------------------------------------------------------------------
// status and interrupt fields
// ----------------------------------------------------------------------
`define OPC_INT_W 4
`define OPC_INT_RESET 4'h0
`define OPC_I_OT_SET 0
`define OPC_I_OT_CLR 1
`define OPC_I_PUMP_UP 2
`define OPC_I_HP_UP 3

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define OPC_RESP_OKAY 2'h0
`define OPC_RESP_SLVERR 2'h2

`endif

//--- core/opc_pkg.sv
package opc_pkg;
    typedef enum logic [1:0] {PUMP_OFF, PUMP_RAMP, PUMP_ON} opc_pump_state_type;
    typedef enum logic [1:0] {HP_OFF, HP_RAMP, HP_ON} opc_hp_state_type;
    typedef enum logic [1:0] {SPK_OFF, SPK_SAVE, SPK_NORMAL} opc_spk_state_type;
endpackage

//--- core/opc_delay_timer.sv
`timescale 1ns/1ps
module opc_delay_timer #(
    parameter int CYCLES = 440000
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_run,
    output logic o_done
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic done_reg;
    logic done_next;

    // counts while run is held; dropping run restarts from zero
    always_comb begin
        count_next = '0;
        done_next = 1'b0;
        if (i_run) begin
            count_next = (count_reg == LAST) ? count_reg : CW'(count_reg + 1'b1);
            done_next = (count_reg == LAST);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            done_reg <= done_next;
        end
    end

    assign o_done = done_reg;
endmodule // opc_delay_timer

//--- core/opc_power_ctrl.sv
`timescale 1ns/1ps
`include "opc_defs.svh"
module opc_power_ctrl #(
    parameter int DATA_W = 24,
    parameter int PUMP_UP_CYCLES = `OPC_PUMP_UP_NS / `OPC_CLK_PERIOD_NS,
    parameter int HP_UP_CYCLES = `OPC_HP_UP_NS / `OPC_CLK_PERIOD_NS
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    // axi4-lite slave
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    // sensor and audio
    input wire logic i_overtemp,
    input wire logic signed [DATA_W-1:0] i_dac_left,
    input wire logic signed [DATA_W-1:0] i_dac_right,
    // power and pin controls
    output logic o_pump_en,
    output logic o_pump_hi_perf,
    output logic o_rail_to_hp,
    output logic o_rail_to_spk,
    output logic o_hp_drive,
    output logic o_hp_pulldown,
    output logic o_hp_float,
    output logic signed [DATA_W-1:0] o_hp_left_data,
    output logic signed [DATA_W-1:0] o_hp_right_data,
    output logic o_spk_pos_oe_n,
    output logic o_spk_neg_oe_n,
    output logic o_spk_neg_half,
    output logic signed [DATA_W-1:0] o_spk_data,
    output logic [2:0] o_spk_gain_code,
    output logic o_overtemp_flag,
    output logic o_irq
);
    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    logic aw_rdy_reg, aw_rdy_next, w_rdy_reg, w_rdy_next;
    logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next, ar_rdy_reg, ar_rdy_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic commit;
    logic [`OPC_CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic [`OPC_INT_W-1:0] int_stat_reg, int_stat_next, int_mask_reg, int_mask_next;
    logic [`OPC_INT_W-1:0] events;
    logic [31:0] status_word;
    logic flag_reg, flag_next;
    opc_pkg::opc_pump_state_type pump_st_reg, pump_st_next;
    opc_pkg::opc_hp_state_type hp_st_reg, hp_st_next;
    opc_pkg::opc_spk_state_type spk_st_reg, spk_st_next;

    // a write lands only once both halves are held and no answer is pending
    assign commit = aw_full_reg && w_full_reg && !bvalid_reg;
    always_comb begin
        aw_rdy_next = aw_rdy_reg;
        w_rdy_next = w_rdy_reg;
        aw_full_next = aw_full_reg;
        w_full_next = w_full_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (i_s_axi_awvalid && aw_rdy_reg) begin
            aw_rdy_next = 1'b0;
            aw_full_next = 1'b1;
            aw_addr_next = i_s_axi_awaddr;
        end
        if (i_s_axi_wvalid && w_rdy_reg) begin
            w_rdy_next = 1'b0;
            w_full_next = 1'b1;
            w_data_next = i_s_axi_wdata;
            w_strb_next = i_s_axi_wstrb;
        end
        if (commit) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (aw_addr_reg == `OPC_ADDR_CTRL || aw_addr_reg == `OPC_ADDR_STATUS ||
                          aw_addr_reg == `OPC_ADDR_INT_STATUS ||
                          aw_addr_reg == `OPC_ADDR_INT_MASK) ? `OPC_RESP_OKAY : `OPC_RESP_SLVERR;
        end
        if (bvalid_reg && i_s_axi_bready) begin
            bvalid_next = 1'b0;
            aw_rdy_next = 1'b1;
            w_rdy_next = 1'b1;
        end
    end

    // status shows live power states; the flag has no write path at all
    assign status_word = {26'h0, spk_st_reg == opc_pkg::SPK_NORMAL,
                          spk_st_reg == opc_pkg::SPK_SAVE, hp_st_reg == opc_pkg::HP_ON,
                          hp_st_reg == opc_pkg::HP_RAMP, pump_st_reg == opc_pkg::PUMP_ON,
                          flag_reg};
    always_comb begin
        ar_rdy_next = ar_rdy_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (i_s_axi_arvalid && ar_rdy_reg) begin
            ar_rdy_next = 1'b0;
            rvalid_next = 1'b1;
            rresp_next = `OPC_RESP_OKAY;
            unique case (i_s_axi_araddr)
                `OPC_ADDR_CTRL: rdata_next = {20'h0, ctrl_reg};
                `OPC_ADDR_STATUS: rdata_next = status_word;
                `OPC_ADDR_INT_STATUS: rdata_next = {28'h0, int_stat_reg};
                `OPC_ADDR_INT_MASK: rdata_next = {28'h0, int_mask_reg};
                default: begin
                    rdata_next = 32'h0;
                    rresp_next = `OPC_RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_reg && i_s_axi_rready) begin
            rvalid_next = 1'b0;
            ar_rdy_next = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_rdy_reg <= 1'b1;
            w_rdy_reg <= 1'b1;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `OPC_RESP_OKAY;
            ar_rdy_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= `OPC_RESP_OKAY;
        end else begin
            aw_rdy_reg <= aw_rdy_next;
            w_rdy_reg <= w_rdy_next;
            aw_full_reg <= aw_full_next;
            w_full_reg <= w_full_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            ar_rdy_reg <= ar_rdy_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // ------------------------------------------------------------------
    // control and interrupt registers
    // ------------------------------------------------------------------
    // hardware events win over a same-cycle write-one-to-clear
    always_comb begin
        ctrl_next = ctrl_reg;
        int_mask_next = int_mask_reg;
        int_stat_next = int_stat_reg;
        if (commit && aw_addr_reg == `OPC_ADDR_CTRL) begin
            if (w_strb_reg[0]) ctrl_next[7:0] = w_data_reg[7:0];
            if (w_strb_reg[1]) ctrl_next[11:8] = w_data_reg[11:8];
        end
        if (commit && aw_addr_reg == `OPC_ADDR_INT_MASK && w_strb_reg[0])
            int_mask_next = w_data_reg[`OPC_INT_W-1:0];
        if (commit && aw_addr_reg == `OPC_ADDR_INT_STATUS && w_strb_reg[0])
            int_stat_next = int_stat_reg & ~w_data_reg[`OPC_INT_W-1:0];
        int_stat_next = int_stat_next | events;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= `OPC_CTRL_RESET;
            int_mask_reg <= `OPC_INT_RESET;
            int_stat_reg <= `OPC_INT_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            int_mask_reg <= int_mask_next;
            int_stat_reg <= int_stat_next;
        end
    end

    // ------------------------------------------------------------------
    // power sequencing
    // ------------------------------------------------------------------
    logic pump_req, hp_want, spk_want, pump_done, hp_done, all_off;
    logic low_supply_mode, spk_en;

    assign low_supply_mode = ctrl_reg[`OPC_F_LSV];
    assign spk_en = ctrl_reg[`OPC_F_SPK];
    assign pump_req = ctrl_reg[`OPC_F_VCM] && !i_overtemp &&
                      (ctrl_reg[`OPC_F_HPL] || ctrl_reg[`OPC_F_HPR] || (low_supply_mode && spk_en));
    assign hp_want = ctrl_reg[`OPC_F_HPL] && ctrl_reg[`OPC_F_HPR] &&
                     !ctrl_reg[`OPC_F_FLOAT] && !i_overtemp;
    // speaker waits for pump in low supply
    assign spk_want = spk_en && !i_overtemp && (!low_supply_mode || pump_st_reg == opc_pkg::PUMP_ON);

    opc_delay_timer #(.CYCLES(PUMP_UP_CYCLES)) u_pump_timer (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_run(pump_st_reg == opc_pkg::PUMP_RAMP),
        .o_done(pump_done)
    );
    opc_delay_timer #(.CYCLES(HP_UP_CYCLES)) u_hp_timer (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_run(hp_st_reg == opc_pkg::HP_RAMP),
        .o_done(hp_done)
    );

    // state walks; losing a request always drops straight to off
    always_comb begin
        pump_st_next = pump_st_reg;
        hp_st_next = hp_st_reg;
        spk_st_next = spk_st_reg;
        unique case (pump_st_reg)
            opc_pkg::PUMP_OFF: if (pump_req) pump_st_next = opc_pkg::PUMP_RAMP;
            opc_pkg::PUMP_RAMP: begin
                if (!pump_req) pump_st_next = opc_pkg::PUMP_OFF;
                else if (pump_done) pump_st_next = opc_pkg::PUMP_ON;
            end
            default: if (!pump_req) pump_st_next = opc_pkg::PUMP_OFF;
        endcase
        unique case (hp_st_reg)
            opc_pkg::HP_OFF: begin
                if (hp_want && pump_st_reg == opc_pkg::PUMP_ON) hp_st_next = opc_pkg::HP_RAMP;
            end
            opc_pkg::HP_RAMP: begin
                if (!hp_want || pump_st_reg != opc_pkg::PUMP_ON) hp_st_next = opc_pkg::HP_OFF;
                else if (hp_done) hp_st_next = opc_pkg::HP_ON;
            end
            default: begin
                if (!hp_want || pump_st_reg != opc_pkg::PUMP_ON) hp_st_next = opc_pkg::HP_OFF;
            end
        endcase
        unique case (spk_st_reg)
            opc_pkg::SPK_OFF: if (spk_want) spk_st_next = opc_pkg::SPK_SAVE;
            opc_pkg::SPK_SAVE: begin
                if (!spk_want) spk_st_next = opc_pkg::SPK_OFF;
                else if (ctrl_reg[`OPC_F_SAVE_EXIT]) spk_st_next = opc_pkg::SPK_NORMAL;
            end
            default: begin
                if (!spk_want) spk_st_next = opc_pkg::SPK_OFF;
                else if (!ctrl_reg[`OPC_F_SAVE_EXIT]) spk_st_next = opc_pkg::SPK_SAVE;
            end
        endcase
    end

    // flag rises only once all stages are off
    assign all_off = pump_st_reg == opc_pkg::PUMP_OFF && hp_st_reg == opc_pkg::HP_OFF &&
                     spk_st_reg == opc_pkg::SPK_OFF;
    assign flag_next = i_overtemp && (flag_reg || all_off);
    assign events = {hp_done && hp_st_reg == opc_pkg::HP_RAMP,
                     pump_done && pump_st_reg == opc_pkg::PUMP_RAMP,
                     flag_reg && !flag_next, !flag_reg && flag_next};

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pump_st_reg <= opc_pkg::PUMP_OFF;
            hp_st_reg <= opc_pkg::HP_OFF;
            spk_st_reg <= opc_pkg::SPK_OFF;
            flag_reg <= 1'b0;
        end else begin
            pump_st_reg <= pump_st_next;
            hp_st_reg <= hp_st_next;
            spk_st_reg <= spk_st_next;
            flag_reg <= flag_next;
        end
    end

    // ------------------------------------------------------------------
    // pins and audio path
    // ------------------------------------------------------------------
    logic signed [DATA_W:0] sum;
    logic signed [DATA_W-1:0] avg;
    logic hp_on, spk_norm, hp_both_off;
    logic [13:0] pins_reg, pins_next;
    logic signed [DATA_W-1:0] hpl_reg, hpl_next, hpr_reg, hpr_next, spkd_reg, spkd_next;

    assign sum = {i_dac_left[DATA_W-1], i_dac_left} + {i_dac_right[DATA_W-1], i_dac_right};
    assign avg = sum[DATA_W:1];
    assign hp_on = hp_st_reg == opc_pkg::HP_ON;
    assign spk_norm = spk_st_reg == opc_pkg::SPK_NORMAL;
    assign hp_both_off = !ctrl_reg[`OPC_F_HPL] && !ctrl_reg[`OPC_F_HPR];

    always_comb begin
        hpl_next = hp_on ? (ctrl_reg[`OPC_F_MONO] ? avg : i_dac_left) : '0;
        hpr_next = hp_on ? (ctrl_reg[`OPC_F_MONO] ? avg : i_dac_right) : '0;
        spkd_next = spk_norm ? avg : '0;
        pins_next = '0;
        pins_next[0] = pump_st_reg != opc_pkg::PUMP_OFF;
        pins_next[1] = ctrl_reg[`OPC_F_PUMP_CLK];
        pins_next[2] = pump_st_reg == opc_pkg::PUMP_ON;
        pins_next[3] = pump_st_reg == opc_pkg::PUMP_ON && low_supply_mode &&
                       spk_st_reg != opc_pkg::SPK_OFF;
        // pull-down or float when off; unsupported mixes float
        pins_next[4] = hp_on;
        pins_next[5] = !hp_on && hp_both_off && !ctrl_reg[`OPC_F_FLOAT];
        pins_next[6] = !hp_on && !(hp_both_off && !ctrl_reg[`OPC_F_FLOAT]);
        pins_next[7] = !spk_norm;
        pins_next[8] = spk_st_reg == opc_pkg::SPK_OFF;
        pins_next[9] = spk_st_reg == opc_pkg::SPK_SAVE;
        pins_next[12:10] = {1'b0, ctrl_reg[11:10]} + {2'b00, ctrl_reg[`OPC_F_ALC]};
        pins_next[13] = |(int_stat_next & int_mask_next);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pins_reg <= 14'h01a0;
            hpl_reg <= '0;
            hpr_reg <= '0;
            spkd_reg <= '0;
        end else begin
            pins_reg <= pins_next;
            hpl_reg <= hpl_next;
            hpr_reg <= hpr_next;
            spkd_reg <= spkd_next;
        end
    end

    assign o_s_axi_awready = aw_rdy_reg;
    assign o_s_axi_wready = w_rdy_reg;
    assign o_s_axi_bvalid = bvalid_reg;
    assign o_s_axi_bresp = bresp_reg;
    assign o_s_axi_arready = ar_rdy_reg;
    assign o_s_axi_rvalid = rvalid_reg;
    assign o_s_axi_rdata = rdata_reg;
    assign o_s_axi_rresp = rresp_reg;
    assign {o_irq, o_spk_gain_code, o_spk_neg_half, o_spk_neg_oe_n, o_spk_pos_oe_n,
            o_hp_float, o_hp_pulldown, o_hp_drive, o_rail_to_spk, o_rail_to_hp,
            o_pump_hi_perf, o_pump_en} = pins_reg;
    assign o_hp_left_data = hpl_reg;
    assign o_hp_right_data = hpr_reg;
    assign o_spk_data = spkd_reg;
    assign o_overtemp_flag = flag_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_hot2;
        i_overtemp [*2];
    endsequence
    sequence s_spk_from_off;
        spk_st_reg == opc_pkg::SPK_OFF ##1 spk_st_reg != opc_pkg::SPK_OFF;
    endsequence

    property p_pump_start;
        pump_req && pump_st_reg == opc_pkg::PUMP_OFF |=> pump_st_reg == opc_pkg::PUMP_RAMP;
    endproperty
    a_pump_start: assert property (p_pump_start) else $error("pump did not start");
    property p_vcm_gate;
        !ctrl_reg[`OPC_F_VCM] |=> pump_st_reg == opc_pkg::PUMP_OFF;
    endproperty
    a_vcm_gate: assert property (p_vcm_gate) else $error("pump on without vcm");
    property p_hp_after_pump;
        hp_st_reg != opc_pkg::HP_OFF |-> $past(pump_st_reg) == opc_pkg::PUMP_ON;
    endproperty
    a_hp_after_pump: assert property (p_hp_after_pump) else $error("hp before pump");
    property p_spk_rail;
        o_rail_to_spk |-> $past(low_supply_mode) && o_rail_to_hp;
    endproperty
    a_spk_rail: assert property (p_spk_rail) else $error("speaker rail misrouted");
    property p_mono;
        hp_on && ctrl_reg[`OPC_F_MONO] |=> o_hp_left_data == o_hp_right_data;
    endproperty
    a_mono: assert property (p_mono) else $error("mono mix differs");
    property p_hp_drop;
        hp_st_reg != opc_pkg::HP_OFF && !hp_want |=> hp_st_reg == opc_pkg::HP_OFF ##1 !o_hp_drive;
    endproperty
    a_hp_drop: assert property (p_hp_drop) else $error("hp did not drop at once");
    property p_gain;
        ##1 o_spk_gain_code == $past(ctrl_reg[11:10]) + $past(ctrl_reg[`OPC_F_ALC]);
    endproperty
    a_gain: assert property (p_gain) else $error("speaker gain code wrong");
    property p_spk_off_pins;
        spk_st_reg == opc_pkg::SPK_OFF |=> o_spk_pos_oe_n && o_spk_neg_oe_n;
    endproperty
    a_spk_off_pins: assert property (p_spk_off_pins) else $error("speaker pins driven");
    property p_save_first;
        s_spk_from_off |-> spk_st_reg == opc_pkg::SPK_SAVE;
    endproperty
    a_save_first: assert property (p_save_first) else $error("skipped power-save");
    property p_hot;
        s_hot2 |=> all_off && flag_reg;
    endproperty
    a_hot: assert property (p_hot) else $error("overtemp shutdown missing");
    property p_cool;
        flag_reg && !i_overtemp |=> !flag_reg;
    endproperty
    a_cool: assert property (p_cool) else $error("flag did not clear");
endmodule // opc_power_ctrl

//--- bench/output_amp_power_control_test.sv
`timescale 1ns/1ps
module output_amp_power_control_test;
// ----------------------------------------------------------------------
// signals, named as the ports so that .* binds them
// ----------------------------------------------------------------------
logic i_clk = 0, i_rst_n = 0, i_overtemp = 0;
logic i_s_axi_awvalid = 0, i_s_axi_wvalid = 0, i_s_axi_bready = 0;
logic i_s_axi_arvalid = 0, i_s_axi_rready = 0;
logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, rdat;
logic [3:0] i_s_axi_wstrb = 4'hf;
logic signed [23:0] i_dac_left = 24'h000064, i_dac_right = 24'h00012c;
logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
logic o_s_axi_rvalid, o_pump_en, o_pump_hi_perf, o_rail_to_hp, o_rail_to_spk;
logic o_hp_drive, o_hp_pulldown, o_hp_float, o_spk_pos_oe_n, o_spk_neg_oe_n;
logic o_spk_neg_half, o_overtemp_flag, o_irq, ah, wh, bh;
logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rsp;
logic signed [23:0] o_hp_left_data, o_hp_right_data, o_spk_data;
logic [2:0] o_spk_gain_code;
int n_fail = 0, checks_done = 0;
// short ramps keep the run small
opc_power_ctrl #(.PUMP_UP_CYCLES(8), .HP_UP_CYCLES(8)) dut (.*);
// free-running core clock
always #12.5 i_clk = ~i_clk;
// ----------------------------------------------------------------------
// helpers: bench drives at rising edges, samples at falling edges
// ----------------------------------------------------------------------
task end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask
task hang();
    n_fail++;
    $display("Error %0t: wait ran out", $time);
    end_of_test();
endtask
task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
        n_fail++;
        $display("Error %0t: got %h want %h", $time, seen, exp);
    end
endtask
task wt(input int n);
    repeat (n) @(negedge i_clk);
endtask
// each channel released at the edge that takes it
task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'h7;
    for (int k = 0; k < 50; k++) begin
        @(negedge i_clk);
        ah = i_s_axi_awvalid & o_s_axi_awready;
        wh = i_s_axi_wvalid & o_s_axi_wready;
        bh = o_s_axi_bvalid & i_s_axi_bready;
        rsp = o_s_axi_bresp;
        @(posedge i_clk);
        if (ah) i_s_axi_awvalid <= 1'b0;
        if (wh) i_s_axi_wvalid <= 1'b0;
        if (bh) begin
            i_s_axi_bready <= 1'b0;
            return;
        end
    end
    hang();
endtask
task rd(input logic [7:0] a);
    @(posedge i_clk);
    i_s_axi_araddr <= a;
    {i_s_axi_arvalid, i_s_axi_rready} <= 2'h3;
    for (int k = 0; k < 50; k++) begin
        @(negedge i_clk);
        ah = i_s_axi_arvalid & o_s_axi_arready;
        bh = o_s_axi_rvalid & i_s_axi_rready;
        rdat = o_s_axi_rdata;
        rsp = o_s_axi_rresp;
        @(posedge i_clk);
        if (ah) i_s_axi_arvalid <= 1'b0;
        if (bh) begin
            i_s_axi_rready <= 1'b0;
            return;
        end
    end
    hang();
endtask
// pump ramp then driver ramp, bounded
task wait_hp();
    for (int k = 0; k < 200; k++) begin
        if (o_hp_drive === 1'b1) return;
        @(negedge i_clk);
    end
    hang();
endtask
// ----------------------------------------------------------------------
// main sequence
// ----------------------------------------------------------------------
initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wt(1);
    chk(o_hp_pulldown, 1);
    wr(8'h00, 32'h0000004f);
    wt(2);
    chk({o_pump_en, o_pump_hi_perf, o_hp_drive}, 3'h6);
    wait_hp();
    chk({o_rail_to_hp, o_rail_to_spk}, 2'h2);
    chk({o_hp_left_data, o_hp_right_data}, 48'h00006400012c);
    wr(8'h00, 32'h000000cf);
    wt(3);
    chk({o_hp_left_data, o_hp_right_data}, 48'h0000c80000c8);
    $display("headphone test done");
    wr(8'h0c, 32'h00000001);
    i_overtemp <= 1'b1;
    wt(3);
    chk({o_pump_en, o_hp_drive, o_overtemp_flag, o_irq}, 4'h3);
    wr(8'h04, 32'h00000000);
    chk(rsp, 2'h0);
    rd(8'h04);
    chk(rdat[0], 1);
    wr(8'h08, 32'h00000001);
    i_overtemp <= 1'b0;
    wt(2);
    chk({o_overtemp_flag, o_irq}, 2'h0);
    rd(8'h08);
    chk(rdat, 32'h0000000e);
    wait_hp();
    $display("overtemp test done");
    wr(8'h00, 32'h000001cf);
    wt(3);
    chk({o_hp_drive, o_hp_float}, 2'h1);
    wr(8'h00, 32'h00000101);
    wt(2);
    chk({o_pump_en, o_pump_hi_perf, o_hp_drive, o_hp_pulldown, o_hp_float}, 5'h01);
    wr(8'h00, 32'h00000011);
    wt(3);
    chk({o_spk_pos_oe_n, o_spk_neg_oe_n, o_spk_neg_half, o_rail_to_spk}, 4'ha);
    for (int g = 0; g < 8; g++) begin
        wr(8'h00, 32'h00000031 | (g << 9));
        wt(3);
        chk({o_spk_pos_oe_n, o_spk_neg_oe_n, o_spk_data}, 26'h00000c8);
        chk(o_spk_gain_code, (g >> 1) + (g & 1));
    end
    wr(8'h00, 32'h00000019);
    wt(30);
    chk({o_pump_en, o_rail_to_spk}, 2'h3);
    rd(8'h10);
    chk({rsp, rdat}, 34'h200000000);
    wr(8'h10, 32'h00000000);
    chk(rsp, 2'h2);
    $display("speaker test done");
    end_of_test();
end
endmodule // output_amp_power_control_test
